// ---- common/wdt_pkg.sv ----
// constants and types shared by the watchdog time-out unit
// Function
// - after any system reset the watchdog is disabled and not counting
// - writing one to control bit 7 enables the watchdog and starts counting
// - once enabled, software cannot clear the enable; only reset disables it
// - exactly four time-out lengths: 2^18, 2^22, 2^25, 2^27 clock cycles
// - control bits 1:0 select the active time-out length
// - reaching the selected time-out sets the cause flag to one
// - with interrupt select zero, the default, time-out triggers a system reset
// - a watchdog reset is driven as a pulse 64 clock cycles long
// - the reset pulse asserts and deasserts on rising clock edges
// - with interrupt select one, time-out raises a nonmaskable interrupt instead
// - the cause flag stays readable so software can find the event source
// - writing A5h then 5Ah to the restart register reloads the count
// - the cause flag reads zero after an external reset
`default_nettype none
package wdt_pkg;
	// control register field positions
	localparam int unsigned CTL_EN_BIT = 7;
	localparam int unsigned CTL_NMI_BIT = 6;
	localparam int unsigned CTL_FLAG_BIT = 5;
	localparam int unsigned CTL_PERIOD_LSB = 0;
	localparam int unsigned CTL_PERIOD_W = 2;
	// reset values
	localparam logic CTL_EN_RESET = 1'b0;
	localparam logic CTL_NMI_RESET = 1'b0;
	localparam logic CTL_FLAG_RESET = 1'b0;
	localparam logic [1:0] CTL_PERIOD_RESET = 2'h0;
	// period select codes
	localparam logic [1:0] PERIOD_SEL_27 = 2'h0;
	localparam logic [1:0] PERIOD_SEL_25 = 2'h1;
	localparam logic [1:0] PERIOD_SEL_22 = 2'h2;
	localparam logic [1:0] PERIOD_SEL_18 = 2'h3;
	// time-out lengths as powers of two, in clock cycles
	localparam int unsigned EXP_SEL0 = 27;
	localparam int unsigned EXP_SEL1 = 25;
	localparam int unsigned EXP_SEL2 = 22;
	localparam int unsigned EXP_SEL3 = 18;
	localparam int unsigned COUNT_W = 27;
	// restart key pair
	localparam logic [7:0] RESTART_KEY1 = 8'ha5;
	localparam logic [7:0] RESTART_KEY2 = 8'h5a;
	// reset pulse width in clock cycles
	localparam int unsigned RST_PULSE_CYCLES = 64;
	typedef enum logic {SEQ_IDLE, SEQ_ARMED} restart_seq_e;
endpackage
`default_nettype wire

// ---- design/wdt_reset_pulse.sv ----
// fixed-width synchronous reset pulse generator
`default_nettype none
module wdt_reset_pulse
	import wdt_pkg::*;
#(
	parameter int unsigned WIDTH = RST_PULSE_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	output logic pulse
);
	localparam int unsigned CW = $clog2(WIDTH + 1);
	localparam logic [CW-1:0] LOAD = CW'(WIDTH - 1);

	logic [CW-1:0] remain;
	logic [CW-1:0] next_remain;
	logic next_pulse;
	logic [7:0] high_len;

	////////////////////////////////////////////////////////////////////////
	// a start while busy is ignored; the pulse is never stretched
	assign next_pulse = pulse ? (remain != '0) : start;
	assign next_remain = pulse ? remain - CW'(1) : LOAD;

	// edge-aligned pulse
	// both edges come straight off a flop clocked on the rising edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pulse <= 1'b0;
			remain <= '0;
		end else begin
			pulse <= next_pulse;
			remain <= next_remain;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// helper: counts high cycles for the width check
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			high_len <= 8'h00;
		end else begin
			high_len <= pulse ? high_len + 8'h01 : 8'h00;
		end
	end

	chk_pulse_width: assert property (@(posedge clk) disable iff (!nrst)
		$fell(pulse) |-> high_len == 8'(WIDTH))
		else $error("reset pulse width differs from the set width");
	chk_pulse_start: assert property (@(posedge clk) disable iff (!nrst)
		start && !pulse |=> pulse)
		else $error("reset pulse did not start on the next rising edge");
endmodule
`default_nettype wire

// ---- design/watchdog_timeout_unit.sv ----
// watchdog timer: period select, restart keys, reset pulse or nmi on time-out
`default_nettype none
module watchdog_timeout_unit
	import wdt_pkg::*;
#(
	parameter int unsigned TIMEOUT_SEL0 = 2 ** EXP_SEL0,
	parameter int unsigned TIMEOUT_SEL1 = 2 ** EXP_SEL1,
	parameter int unsigned TIMEOUT_SEL2 = 2 ** EXP_SEL2,
	parameter int unsigned TIMEOUT_SEL3 = 2 ** EXP_SEL3,
	parameter int unsigned PULSE_CYCLES = RST_PULSE_CYCLES
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CTL_WR,
	input wire logic [7:0] CTL_WDATA,
	output logic [7:0] CTL_RDATA,
	input wire logic RR_WR,
	input wire logic [7:0] RR_WDATA,
	output logic NMI_REQ,
	output logic SYS_RST_REQ
);
	// terminal counts: counting starts at zero, so a period of n ends at n-1
	localparam logic [COUNT_W-1:0] LIMIT0 = COUNT_W'(TIMEOUT_SEL0 - 1);
	localparam logic [COUNT_W-1:0] LIMIT1 = COUNT_W'(TIMEOUT_SEL1 - 1);
	localparam logic [COUNT_W-1:0] LIMIT2 = COUNT_W'(TIMEOUT_SEL2 - 1);
	localparam logic [COUNT_W-1:0] LIMIT3 = COUNT_W'(TIMEOUT_SEL3 - 1);

	// control fields, counter and key sequencer state
	logic watchdog_enable_bit;
	logic nmi_select;
	logic cause_flag;
	logic [1:0] timeout_period_select;
	logic [COUNT_W-1:0] count;
	logic [COUNT_W-1:0] next_count;
	logic [COUNT_W-1:0] timeout_limit;
	restart_seq_e seq;
	restart_seq_e next_seq;
	logic timeout;
	logic fire_reset;
	logic ctl_write_ok;
	logic key1_seen;
	logic key2_seen;
	logic restart;

	////////////////////////////////////////////////////////////////////////
	// period decode
	assign timeout_limit = (timeout_period_select == PERIOD_SEL_27) ? LIMIT0 :
		(timeout_period_select == PERIOD_SEL_25) ? LIMIT1 :
		(timeout_period_select == PERIOD_SEL_22) ? LIMIT2 : LIMIT3;

	// terminal count
	// count runs 0..limit, so time-out lands after exactly 2^n cycles
	assign timeout = watchdog_enable_bit && (count == timeout_limit);
	assign fire_reset = timeout && !nmi_select;
	// cpu is held in reset during the pulse, so its control writes are dropped
	assign ctl_write_ok = CTL_WR && !SYS_RST_REQ;

	////////////////////////////////////////////////////////////////////////
	// restart key decode
	assign key1_seen = RR_WR && (RR_WDATA == RESTART_KEY1);
	assign key2_seen = RR_WR && (RR_WDATA == RESTART_KEY2);
	// key pair reload
	// a time-out in the same cycle wins: the pair came too late
	assign restart = (seq == SEQ_ARMED) && key2_seen && !timeout;

	// key sequencer; any wrong byte drops the first key
	always_comb begin
		next_seq = seq;
		case (seq)
			SEQ_IDLE: begin
				if (key1_seen) begin
					next_seq = SEQ_ARMED;
				end
			end
			// a repeated first key keeps the sequencer armed
			SEQ_ARMED: begin
				if (RR_WR && !key1_seen) begin
					next_seq = SEQ_IDLE;
				end
			end
			default: begin
				next_seq = SEQ_IDLE;
			end
		endcase
		if (timeout) begin
			next_seq = SEQ_IDLE;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			seq <= SEQ_IDLE;
		end else begin
			seq <= next_seq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counter held while disabled
	// no time-out is possible until the enable bit is set
	// a period shortened below the current count waits for the 27-bit wrap
	assign next_count = (!watchdog_enable_bit || restart || timeout) ?
		'0 : count + COUNT_W'(1);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// disabled after any reset
	// a watchdog reset clears enable, nmi select and period like a system reset would; the cause flag is kept
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			watchdog_enable_bit <= CTL_EN_RESET;
			nmi_select <= CTL_NMI_RESET;
			timeout_period_select <= CTL_PERIOD_RESET;
		end else if (fire_reset) begin
			watchdog_enable_bit <= CTL_EN_RESET;
			nmi_select <= CTL_NMI_RESET;
			timeout_period_select <= CTL_PERIOD_RESET;
		end else if (ctl_write_ok) begin
			watchdog_enable_bit <= watchdog_enable_bit | CTL_WDATA[CTL_EN_BIT];
			nmi_select <= CTL_WDATA[CTL_NMI_BIT];
			timeout_period_select <= CTL_WDATA[CTL_PERIOD_LSB +: CTL_PERIOD_W];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cause flag set
	// cleared only by the external reset
	// the flag must survive the watchdog's own reset pulse to be useful
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cause_flag <= CTL_FLAG_RESET;
		end else if (timeout) begin
			cause_flag <= 1'b1;
		end
	end

	// nmi instead of reset
	// one-cycle request; counting restarts so the next one is a full period away
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			NMI_REQ <= 1'b0;
		end else begin
			NMI_REQ <= timeout && nmi_select;
		end
	end

	// readable cause flag
	// reserved bits read as zero
	assign CTL_RDATA = {watchdog_enable_bit, nmi_select, cause_flag, 3'h0,
		timeout_period_select};

	////////////////////////////////////////////////////////////////////////
	// fixed reset pulse
	wdt_reset_pulse #(
		.WIDTH(PULSE_CYCLES)
	) u_pulse (
		.clk(CLK),
		.nrst(NRST),
		.start(fire_reset),
		.pulse(SYS_RST_REQ)
	);

	////////////////////////////////////////////////////////////////////////
	// all checks run on the system clock; all but chk_flag_cold pause while the external reset is low
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	chk_enable_sticky: assert property (
		$fell(watchdog_enable_bit) |-> $past(fire_reset))
		else $error("enable bit cleared without a watchdog reset");
	chk_enable_write: assert property (
		ctl_write_ok && CTL_WDATA[CTL_EN_BIT] && !fire_reset |=> CTL_RDATA[CTL_EN_BIT])
		else $error("write of one did not enable the watchdog");
	chk_idle_quiet: assert property (
		!watchdog_enable_bit |=> !NMI_REQ && !$rose(SYS_RST_REQ) && count == '0)
		else $error("disabled watchdog counted or fired");
	chk_period_short: assert property (
		watchdog_enable_bit && timeout_period_select == PERIOD_SEL_18 &&
		count == LIMIT3 |-> timeout)
		else $error("shortest period did not end at its count");
	chk_period_long: assert property (
		timeout && timeout_period_select == PERIOD_SEL_27 |-> count == LIMIT0)
		else $error("period code 00 ended at the wrong count");
	chk_flag_set: assert property (
		timeout |=> cause_flag ##1 cause_flag)
		else $error("cause flag not set by time-out");
	chk_flag_holds: assert property (
		CTL_RDATA[CTL_FLAG_BIT] |=> CTL_RDATA[CTL_FLAG_BIT])
		else $error("cause flag dropped without external reset");
	chk_reset_mode: assert property (
		timeout && !nmi_select |=> SYS_RST_REQ && !NMI_REQ)
		else $error("reset mode time-out gave no reset pulse");
	chk_nmi_mode: assert property (
		timeout && nmi_select |=> NMI_REQ && !SYS_RST_REQ ##1 !NMI_REQ)
		else $error("nmi mode time-out gave wrong response");
	chk_restart_reload: assert property (
		restart |=> count == '0 ##1 count == COUNT_W'(1))
		else $error("restart pair did not reload the count");
	chk_flag_cold: assert property (@(posedge CLK) disable iff (1'b0)
		$rose(NRST) |-> !cause_flag)
		else $error("cause flag set after external reset");

	cov_reset_timeout: cover property (fire_reset ##1 SYS_RST_REQ);
	cov_nmi_timeout: cover property (timeout && nmi_select ##1 NMI_REQ);
	cov_restart: cover property (key1_seen ##[1:20] restart);
	// rarer paths: the shortest period and a write dropped during the pulse
	cov_period_short: cover property (timeout && timeout_period_select == PERIOD_SEL_18);
	cov_write_dropped: cover property (CTL_WR && SYS_RST_REQ);
endmodule
`default_nettype wire

// ---- sim/cpu_model.sv ----
// cpu side model that writes the control and restart registers
`default_nettype none
module cpu_model (
	input wire logic clk,
	output logic ctl_wr,
	output logic [7:0] ctl_wdata,
	output logic rr_wr,
	output logic [7:0] rr_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// strobes idle low from time zero
	initial begin
		ctl_wr = 1'b0;
		ctl_wdata = 8'h00;
		rr_wr = 1'b0;
		rr_wdata = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// control byte write
	task automatic ctl_write(input logic [7:0] value);
		@(negedge clk);
		ctl_wr = 1'b1;
		ctl_wdata = value;
		@(negedge clk);
		ctl_wr = 1'b0;
		ctl_wdata = ~value; // released lines must not look valid
	endtask
	// restart key byte, any gap allowed
	task automatic rr_write(input logic [7:0] value);
		@(negedge clk);
		rr_wr = 1'b1;
		rr_wdata = value;
		@(negedge clk);
		rr_wr = 1'b0;
		rr_wdata = ~value;
	endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the watchdog time-out unit
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// short periods keep the run brief; pulse width kept at full size
	localparam int unsigned T0 = 64;
	localparam int unsigned T1 = 32;
	localparam int unsigned T2 = 16;
	localparam int unsigned T3 = 8;
	int unsigned tout[4] = '{T0, T1, T2, T3};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ctl_wr, rr_wr, nmi_req, sys_rst_req;
	logic [7:0] ctl_wdata, rr_wdata, ctl_rdata;
	int err_total = 0;
	int compares = 0;
	always #5 clk = ~clk;
	watchdog_timeout_unit #(.TIMEOUT_SEL0(T0), .TIMEOUT_SEL1(T1), .TIMEOUT_SEL2(T2),
		.TIMEOUT_SEL3(T3)) watchdog_timeout_unit_inst (
		.CLK(clk), .NRST(nrst), .CTL_WR(ctl_wr), .CTL_WDATA(ctl_wdata),
		.CTL_RDATA(ctl_rdata), .RR_WR(rr_wr), .RR_WDATA(rr_wdata),
		.NMI_REQ(nmi_req), .SYS_RST_REQ(sys_rst_req));
	cpu_model cpu_model_inst (.clk(clk), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
		.rr_wr(rr_wr), .rr_wdata(rr_wdata));
	////////////////////////////////////////////////////////////////
	// shared compare and verdict
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp_val);
		compares++;
		if (seen !== exp_val) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp_val, seen);
		end
	endtask
	task automatic close_out;
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic do_reset;
		@(negedge clk);
		nrst = 1'b0;
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		check("ctl after reset", ctl_rdata, 8'h00);
		check("outs after reset", {6'h0, nmi_req, sys_rst_req}, 8'h00);
	endtask
	// bounded wait for the nmi pulse, then its one-cycle width
	task automatic wait_nmi(input int unsigned want);
		int unsigned n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (nmi_req !== 1'b1 && n < 300);
		if (n >= 300) begin
			err_total++;
			close_out();
		end
		check("nmi delay", 8'(n), 8'(want));
		check("no reset in nmi mode", {7'h0, sys_rst_req}, 8'h00);
		@(negedge clk);
		check("nmi width", {7'h0, nmi_req}, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////
	// reset-mode time-out
	task automatic t_reset_mode;
		int unsigned n;
		do_reset();
		repeat (100) @(negedge clk);
		check("disabled idle", {7'h0, sys_rst_req}, 8'h00);
		cpu_model_inst.ctl_write(8'h83);
		cpu_model_inst.ctl_write(8'h03);
		@(negedge clk);
		check("enable sticks", ctl_rdata, 8'h83);
		// the second write and the check above used three of the T3 cycles
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sys_rst_req !== 1'b1 && n < 300);
		if (n >= 300) begin
			err_total++;
			close_out();
		end
		check("reset delay", 8'(n), 8'(T3 - 3));
		check("no nmi in reset mode", {7'h0, nmi_req}, 8'h00);
		// this write lands inside the pulse and must be dropped
		cpu_model_inst.ctl_write(8'h80);
		// two pulse cycles already went by before the loop
		n = 2;
		while (sys_rst_req === 1'b1 && n < 300) begin
			n++;
			@(negedge clk);
		end
		if (n >= 300) begin
			err_total++;
			close_out();
		end
		check("reset width", 8'(n), 8'(wdt_pkg::RST_PULSE_CYCLES));
		check("cause flag", ctl_rdata, 8'h20);
		do_reset();
		$display("done reset mode");
	endtask
	// every period code in nmi mode
	task automatic t_periods;
		for (int s = 0; s < 4; s++) begin
			do_reset();
			cpu_model_inst.ctl_write(8'hc0 | 8'(s));
			wait_nmi(tout[s]);
			check("flag in nmi mode", ctl_rdata, 8'he0 | 8'(s));
			wait_nmi(tout[s] - 1);
		end
		$display("done periods");
	endtask
	// restart keys, lone second key, broken pair
	task automatic t_restart;
		do_reset();
		cpu_model_inst.ctl_write(8'hc0);
		cpu_model_inst.rr_write(8'h5a);
		wait_nmi(T0 - 2);
		repeat (20) @(negedge clk);
		cpu_model_inst.rr_write(8'ha5);
		repeat (10) @(negedge clk);
		cpu_model_inst.rr_write(8'h5a);
		wait_nmi(T0);
		cpu_model_inst.rr_write(8'ha5);
		cpu_model_inst.rr_write(8'h00);
		cpu_model_inst.rr_write(8'h5a);
		wait_nmi(T0 - 7);
		$display("done restart");
	endtask
	initial begin
		t_reset_mode();
		t_periods();
		t_restart();
		close_out();
	end
endmodule
`default_nettype wire
